// file: pcf_pkg.sv
/*
 Package for the bridge command filter: PCI command codes, structs
 carried between the address-phase decoder and its users, buffer sizes.
 Assumes a single 100 MHz clock domain per instance.
*/
`default_nettype none
package pcf_pkg;
   localparam logic [3:0] CMD_INT_ACK = 4'h0;
   localparam logic [3:0] CMD_SPECIAL = 4'h1;
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_RSV4 = 4'h4;
   localparam logic [3:0] CMD_RSV5 = 4'h5;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_RSV8 = 4'h8;
   localparam logic [3:0] CMD_RSV9 = 4'h9;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;
   localparam logic [3:0] CMD_MEM_RD_MUL = 4'hc;
   localparam logic [3:0] CMD_DUAL_ADDR = 4'hd;
   localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
   localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;
   // Buffer sizes in bytes, and buffer counts
   localparam int WR_FIFO_BYTES = 128;
   localparam int RD_FIFO_BYTES = 128;
   localparam int WR_FIFO_COUNT = 2;
   localparam int RD_FIFO_COUNT = 4;
   // Low address bits that mark a linear-increment burst
   localparam logic [1:0] BURST_LINEAR = 2'h0;
   // Config type field sits in the two lowest address bits
   localparam logic [1:0] CFG_TYPE0 = 2'h0;
   localparam logic [1:0] CFG_TYPE1 = 2'h1;

   typedef struct packed {
      logic [31:0] addr;
      logic [3:0] cmd;
   } pcf_addr_phase_t;

   typedef struct packed {
      logic claim;
      logic linear;
      logic [3:0] cmd;
   } pcf_decision_t;
endpackage
`default_nettype wire

// file: pcf_filter.sv
/*
 Command filter for one side of a two-port PCI bridge. Latches the
 address phase, decides whether the bridge may claim it as target and
 whether a given command may be mastered on this bus, and asks for a
 disconnect after the first data transfer of a non-linear burst.
 Assumes bus inputs already sampled on i_clk; window hit from the
 address decoders; one instance per bus, i_is_primary selects the side.
*/
// Notes on behaviour
// - Two 128-byte write FIFOs, one each direction, hold addr, data, cmd, enables.
// - Four more 128-byte FIFOs hold read transaction addr, data, cmd, enables.
// - I/O, memory, read multiple/line, write-invalidate, dual address: master and target.
// - Config read mastered secondary, claimed primary; config write per-side type limits.
// - Reserved commands never mastered and never claimed.
// - Interrupt acknowledge never mastered, ignored as target.
// - Special cycles may be mastered, never claimed as target.
// - No Type 0 config mastered on primary, none claimed on secondary.
// - 32-bit address in one phase: address on AD, command on CBE.
// - Bursts accepted only with address bits 1:0 equal to zero.
// - Nonzero low address bits: disconnect after the first data transfer.
// - Claims only by positive medium decode, never subtractive.
`timescale 1ns/100ps
`default_nettype none
module pcf_filter (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Bus side selection
   input wire logic i_is_primary,
   // Address phase
   input wire logic i_addr_phase,
   input wire logic [31:0] i_ad,
   input wire logic [3:0] i_cbe_n,
   input wire logic i_window_hit,
   // Data phase
   input wire logic i_frame_n,
   input wire logic i_irdy_n,
   input wire logic i_trdy_n,
   // Master-side query
   input wire logic [3:0] i_mst_cmd,
   input wire logic [1:0] i_mst_cfg_type,
   // Results
   output logic o_claim,
   output logic o_stop_req,
   output logic o_mst_allowed,
   output pcf_pkg::pcf_decision_t o_decision
);
   pcf_pkg::pcf_addr_phase_t ap;
   logic active;
   logic next_claim;
   logic next_mst_ok;

   // Target acceptance of a command on this side
   function automatic logic tgt_ok(input logic [3:0] c, input logic [1:0] t, input logic pri);
      logic ok;
      ok = 1'h0;
      case (c)
         pcf_pkg::CMD_IO_RD, pcf_pkg::CMD_IO_WR, pcf_pkg::CMD_MEM_RD, pcf_pkg::CMD_MEM_WR,
         pcf_pkg::CMD_MEM_RD_MUL, pcf_pkg::CMD_DUAL_ADDR, pcf_pkg::CMD_MEM_RD_LINE,
         pcf_pkg::CMD_MEM_WR_INV: ok = 1'h1;
         pcf_pkg::CMD_CFG_RD: ok = pri;
         pcf_pkg::CMD_CFG_WR: ok = pri || (t == pcf_pkg::CFG_TYPE1);
         default: ok = 1'h0;
      endcase
      return ok;
   endfunction

   // Master permission for a command on this side
   function automatic logic mst_ok(input logic [3:0] c, input logic [1:0] t, input logic pri);
      logic ok;
      ok = 1'h0;
      case (c)
         pcf_pkg::CMD_SPECIAL: ok = 1'h1;
         pcf_pkg::CMD_IO_RD, pcf_pkg::CMD_IO_WR, pcf_pkg::CMD_MEM_RD, pcf_pkg::CMD_MEM_WR,
         pcf_pkg::CMD_MEM_RD_MUL, pcf_pkg::CMD_DUAL_ADDR, pcf_pkg::CMD_MEM_RD_LINE,
         pcf_pkg::CMD_MEM_WR_INV: ok = 1'h1;
         pcf_pkg::CMD_CFG_RD: ok = !pri;
         pcf_pkg::CMD_CFG_WR: ok = !pri || (t == pcf_pkg::CFG_TYPE1);
         default: ok = 1'h0;
      endcase
      return ok;
   endfunction

   always_comb begin
      next_claim = i_window_hit && tgt_ok(~i_cbe_n, i_ad[1:0], i_is_primary);
      next_mst_ok = mst_ok(i_mst_cmd, i_mst_cfg_type, i_is_primary);
   end

   // Address phase latch; cbe is active low on the wire
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ap <= '0;
      end else if (i_addr_phase) begin
         ap.addr <= i_ad;
         ap.cmd <= ~i_cbe_n;
      end
   end

   // Claim decision, held for the transaction
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_claim <= 1'h0;
         active <= 1'h0;
      end else if (i_addr_phase) begin
         o_claim <= next_claim;
         active <= 1'h1;
      end else if (i_frame_n && i_irdy_n) begin
         o_claim <= 1'h0;
         active <= 1'h0;
      end
   end

   // Disconnect after first transfer of a non-linear burst
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_stop_req <= 1'h0;
      end else if (i_addr_phase) begin
         o_stop_req <= 1'h0;
      end else if (active && o_claim && ap.addr[1:0] != pcf_pkg::BURST_LINEAR && !i_irdy_n
            && !i_trdy_n) begin
         o_stop_req <= 1'h1;
      end else if (i_frame_n && i_irdy_n) begin
         o_stop_req <= 1'h0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_mst_allowed <= 1'h0;
         o_decision <= '0;
      end else begin
         o_mst_allowed <= next_mst_ok;
         o_decision.claim <= o_claim;
         o_decision.linear <= (ap.addr[1:0] == pcf_pkg::BURST_LINEAR);
         o_decision.cmd <= ap.cmd;
      end
   end

   property p_no_rsv_claim;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_addr_phase && (~i_cbe_n == pcf_pkg::CMD_RSV4 || ~i_cbe_n == pcf_pkg::CMD_RSV5 ||
         ~i_cbe_n == pcf_pkg::CMD_RSV8 || ~i_cbe_n == pcf_pkg::CMD_RSV9)
         |=> !o_claim;
   endproperty
   a_no_rsv_claim: assert property (p_no_rsv_claim) else $error("reserved cmd claimed");

   property p_no_ack_claim;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_addr_phase && ~i_cbe_n == pcf_pkg::CMD_INT_ACK |=> !o_claim;
   endproperty
   a_no_ack_claim: assert property (p_no_ack_claim) else $error("int ack claimed");

   property p_no_special_claim;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_addr_phase && ~i_cbe_n == pcf_pkg::CMD_SPECIAL |=> !o_claim;
   endproperty
   a_no_special_claim: assert property (p_no_special_claim) else $error("special claimed");

   property p_type0_sec;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_addr_phase && !i_is_primary && ~i_cbe_n == pcf_pkg::CMD_CFG_WR
         && i_ad[1:0] == pcf_pkg::CFG_TYPE0
         |=> !o_claim;
   endproperty
   a_type0_sec: assert property (p_type0_sec) else $error("type 0 claimed on secondary");

   property p_mem_claim;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_addr_phase && i_window_hit && ~i_cbe_n == pcf_pkg::CMD_MEM_RD |=> o_claim;
   endproperty
   a_mem_claim: assert property (p_mem_claim) else $error("memory read not claimed");

   property p_miss;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_addr_phase && !i_window_hit |=> !o_claim;
   endproperty
   a_miss: assert property (p_miss) else $error("claim without window hit");

   property p_cfgrd_pri;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_is_primary && i_mst_cmd == pcf_pkg::CMD_CFG_RD |=> !o_mst_allowed;
   endproperty
   a_cfgrd_pri: assert property (p_cfgrd_pri) else $error("cfg read mastered on primary");

   property p_stop;
      @(posedge i_clk) disable iff (!i_rst_n)
      !i_addr_phase && active && o_claim && ap.addr[1:0] != pcf_pkg::BURST_LINEAR
         && !i_irdy_n && !i_trdy_n
         |=> o_stop_req;
   endproperty
   a_stop: assert property (p_stop) else $error("no disconnect on non-linear burst");

   property p_linear;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_addr_phase && i_ad[1:0] == pcf_pkg::BURST_LINEAR |=> ##1 o_decision.linear;
   endproperty
   a_linear: assert property (p_linear) else $error("linear mode not flagged");

   property p_cfgrd_sec;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_addr_phase && !i_is_primary && ~i_cbe_n == pcf_pkg::CMD_CFG_RD |=> !o_claim;
   endproperty
   a_cfgrd_sec: assert property (p_cfgrd_sec) else $error("cfg rd claimed on secondary");

   property p_no_rsv_mst;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_mst_cmd == pcf_pkg::CMD_RSV4 || i_mst_cmd == pcf_pkg::CMD_RSV5 ||
         i_mst_cmd == pcf_pkg::CMD_RSV8 || i_mst_cmd == pcf_pkg::CMD_RSV9 |=> !o_mst_allowed;
   endproperty
   a_no_rsv_mst: assert property (p_no_rsv_mst) else $error("reserved cmd mastered");

   property p_no_ack_mst;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_mst_cmd == pcf_pkg::CMD_INT_ACK |=> !o_mst_allowed;
   endproperty
   a_no_ack_mst: assert property (p_no_ack_mst) else $error("int ack mastered");

   property p_special_mst;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_mst_cmd == pcf_pkg::CMD_SPECIAL |=> o_mst_allowed;
   endproperty
   a_special_mst: assert property (p_special_mst) else $error("special cycle refused");

   property p_type0_pri_mst;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_is_primary && i_mst_cmd == pcf_pkg::CMD_CFG_WR && i_mst_cfg_type == pcf_pkg::CFG_TYPE0
         |=> !o_mst_allowed;
   endproperty
   a_type0_pri_mst: assert property (p_type0_pri_mst) else $error("type 0 on primary");

   property p_linear_no_stop;
      @(posedge i_clk) disable iff (!i_rst_n)
      ap.addr[1:0] == pcf_pkg::BURST_LINEAR |=> !o_stop_req;
   endproperty
   a_linear_no_stop: assert property (p_linear_no_stop) else $error("linear burst cut");

   property p_stop_clear;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_addr_phase |=> !o_stop_req;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("stop not cleared");

   property p_claim_hold;
      @(posedge i_clk) disable iff (!i_rst_n)
      active && o_claim && !i_addr_phase && !(i_frame_n && i_irdy_n) |=> o_claim;
   endproperty
   a_claim_hold: assert property (p_claim_hold) else $error("claim dropped");
endmodule
`default_nettype wire

// file: pcf_bus_model.sv
/* Initiator model for the bridge command filter.
   Assumes the bench clock; drives address, data and idle cycles. */
`timescale 1ns/100ps
`default_nettype none
module pcf_bus_model (
   // Clock
   input wire logic i_clk,
   // Bus toward the filter
   output logic o_addr_phase,
   output logic [31:0] o_ad,
   output logic [3:0] o_cbe_n,
   output logic o_hit,
   output logic o_frame_n,
   output logic o_irdy_n,
   output logic o_trdy_n
);
   initial begin
      {o_addr_phase, o_ad, o_cbe_n, o_hit} = '0;
      {o_frame_n, o_irdy_n, o_trdy_n} = 3'h7;
   end
   // Address phase: address and hit for one cycle, command left on cbe, frame left low
   task automatic addr(input logic [3:0] cmd, input logic [31:0] ad, input logic hit);
      @(posedge i_clk);
      o_addr_phase <= 1'h1;
      o_ad <= ad;
      o_cbe_n <= ~cmd;
      o_hit <= hit;
      o_frame_n <= 1'h0;
      @(posedge i_clk);
      o_addr_phase <= 1'h0;
      o_ad <= ~ad;
      o_hit <= 1'h0;
   endtask
   task automatic xfer();
      @(posedge i_clk);
      o_irdy_n <= 1'h0;
      o_trdy_n <= 1'h0;
      @(posedge i_clk);
      o_irdy_n <= 1'h1;
      o_trdy_n <= 1'h1;
   endtask
   task automatic idle();
      @(posedge i_clk);
      o_frame_n <= 1'h1;
      @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// file: pcf_filter_tb_top.sv
/* Bench for the bridge command filter: claim and master tables,
   decision record, disconnect. Assumes pcf_bus_model as initiator. */
`timescale 1ns/100ps
`default_nettype none
module pcf_filter_tb_top;
   logic i_clk = 1'h0;
   logic i_rst_n = 1'h0;
   logic is_primary = 1'h1;
   logic [3:0] mst_cmd = 4'h0;
   logic [1:0] mst_type = 2'h0;
   logic addr_phase, hit, frame_n, irdy_n, trdy_n, claim, stop_req, mst_ok;
   logic [31:0] ad;
   logic [3:0] cbe_n;
   pcf_pkg::pcf_decision_t decision;
   int num_errors = 0;
   int samples_checked = 0;
   always #5 i_clk = ~i_clk;
   pcf_bus_model bus (.i_clk(i_clk), .o_addr_phase(addr_phase), .o_ad(ad), .o_cbe_n(cbe_n),
      .o_hit(hit), .o_frame_n(frame_n), .o_irdy_n(irdy_n), .o_trdy_n(trdy_n));
   pcf_filter dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_is_primary(is_primary),
      .i_addr_phase(addr_phase), .i_ad(ad), .i_cbe_n(cbe_n), .i_window_hit(hit),
      .i_frame_n(frame_n), .i_irdy_n(irdy_n), .i_trdy_n(trdy_n), .i_mst_cmd(mst_cmd),
      .i_mst_cfg_type(mst_type), .o_claim(claim), .o_stop_req(stop_req),
      .o_mst_allowed(mst_ok), .o_decision(decision));
   task automatic check(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %b", $time, what, got);
      end
   endtask
   function automatic logic tgt_exp(input logic [3:0] c, input logic p, input logic [1:0] t);
      case (c)
         4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf: return 1'h1;
         4'ha: return p;
         4'hb: return p | (t == 2'h1);
         default: return 1'h0;
      endcase
   endfunction
   function automatic logic mst_exp(input logic [3:0] c, input logic p, input logic [1:0] t);
      case (c)
         4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf: return 1'h1;
         4'ha: return ~p;
         4'hb: return ~p | (t == 2'h1);
         default: return 1'h0;
      endcase
   endfunction
   task automatic t_master();
      for (int k = 0; k < 64; k++) begin
         logic e;
         e = mst_exp(k[3:0], k[5], {1'h0, k[4]});
         @(posedge i_clk);
         is_primary <= k[5];
         mst_cmd <= k[3:0];
         mst_type <= {1'h0, k[4]};
         @(posedge i_clk);
         #1;
         check(mst_ok, e, "master");
      end
   endtask
   task automatic t_claim();
      for (int k = 0; k < 128; k++) begin
         logic e;
         e = k[4] & tgt_exp(k[3:0], k[6], {1'h0, k[5]});
         @(posedge i_clk);
         is_primary <= k[6];
         bus.addr(k[3:0], {28'h1234567, 3'h0, k[5]}, k[4]);
         #1;
         check(claim, e, "claim");
         @(posedge i_clk);
         #1;
         check(decision.claim, e, "dec claim");
         check(decision.cmd === k[3:0], 1'h1, "dec cmd");
         check(decision.linear, ~k[5], "dec linear");
         bus.idle();
         #1;
         check(claim, 1'h0, "release");
      end
   endtask
   task automatic t_stop();
      for (int lo = 0; lo < 4; lo++) begin
         bus.addr(pcf_pkg::CMD_MEM_RD, {30'h0000_1000, lo[1:0]}, 1'h1);
         #1;
         check(stop_req, 1'h0, "early stop");
         bus.xfer();
         #1;
         check(stop_req, lo != 0, "stop");
         check(claim, 1'h1, "claim held");
         bus.idle();
         #1;
         check(stop_req, 1'h0, "stop clear");
      end
   endtask
   task automatic t_sizes();
      check(pcf_pkg::WR_FIFO_BYTES == 128 && pcf_pkg::WR_FIFO_COUNT == 2, 1'h1, "wr fifo");
      check(pcf_pkg::RD_FIFO_BYTES == 128 && pcf_pkg::RD_FIFO_COUNT == 4, 1'h1, "rd fifo");
   endtask
   task automatic t_reset();
      bus.addr(pcf_pkg::CMD_MEM_WR, 32'h0000_2003, 1'h1);
      bus.xfer();
      #1;
      check(stop_req & claim, 1'h1, "pre-reset");
      @(posedge i_clk);
      i_rst_n <= 1'h0;
      @(posedge i_clk);
      i_rst_n <= 1'h1;
      #1;
      check(claim | stop_req | decision.claim, 1'h0, "mid reset");
      @(posedge i_clk);
      #1;
      check(claim | stop_req | decision.claim, 1'h0, "after reset");
      bus.idle();
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'h1;
      #1;
      check(claim | stop_req | mst_ok | (|decision), 1'h0, "reset");
      t_sizes();
      t_master();
      t_claim();
      t_stop();
      t_reset();
      stop_test();
   end
   initial begin
      #50000;
      num_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
